//--- hdl/irbs_sequencer.v
// Machine-cycle bus sequencer for relative, branch-to-subroutine and indexed instructions.
// Summary of operation
// - Indexed address is index register plus unsigned offset byte, 0 to 255.
// - Uncarried index plus offset appears first with address_valid low; carried later.
// - Indexed jump: fetch, offset, dummy at index, dummy at uncarried sum.
// - Indexed 8-bit ops add a fifth cycle reading operand at carried sum.
// - Index compare and 16-bit loads read high then low byte, six cycles.
// - Accumulator store: three dummy cycles, then write at carried sum in cycle six.
// - Branches: fetch, offset, dummy at opcode plus two, dummy at target.
// - Branch-to-subroutine lasts eight cycles; cycle three shows return address, invalid.
// - Cycle four writes return address low byte at stack pointer.
// - Cycle five writes high byte at stack pointer minus one; three dummies follow.
// - Test operand keeps address_valid low in its last cycle, no write.
// - Taken branch goes to address after the instruction plus offset; else sequential.
// - Branch offset is signed, reaching 126 below to 129 above the opcode.
`include "irbs_map.vh"

module irbs_sequencer (
  input  wire        i_mclk,
  input  wire        i_reset,
  input  wire        i_ce,
  input  wire [7:0]  i_data,
  input  wire [15:0] i_index,
  input  wire [15:0] i_stack_ptr,
  input  wire [7:0]  i_accum,
  input  wire        i_cond_met,
  output reg  [15:0] o_addr,
  output reg         o_address_valid,
  output reg         o_rw,
  output reg  [7:0]  o_data_out,
  output reg         o_data_oe,
  output reg  [15:0] o_pc,
  output reg  [15:0] o_operand,
  output reg         o_operand_valid,
  output reg         o_instr_done
);

  // One machine cycle per enabled clock; state names give the cycle number.
  localparam [7:0] S_C1 = 8'h01;
  localparam [7:0] S_C2 = 8'h02;
  localparam [7:0] S_C3 = 8'h04;
  localparam [7:0] S_C4 = 8'h08;
  localparam [7:0] S_C5 = 8'h10;
  localparam [7:0] S_C6 = 8'h20;
  localparam [7:0] S_C7 = 8'h40;
  localparam [7:0] S_C8 = 8'h80;

  reg  [7:0]  state_reg;
  reg  [7:0]  state_next;
  reg  [2:0]  class_reg;
  reg  [7:0]  offset_reg;
  reg         taken_reg;
  reg  [15:0] pc_reg;
  reg  [15:0] pc_next;
  reg  [15:0] addr_next;
  reg         vma_next;
  reg         rw_next;
  reg  [7:0]  dout_next;
  reg         oe_next;
  reg         last_cycle;
  reg         cap_high;
  reg         cap_low;
  wire [2:0]  dec_class;
  wire [2:0]  cls;
  wire [15:0] pc_plus1;
  wire [15:0] ret_addr;
  wire [15:0] rel_target;
  wire [15:0] idx_uncarried;
  wire [15:0] idx_carried;
  wire [15:0] idx_carried_p1;
  wire [15:0] sp_minus1;
  wire [15:0] sp_minus2;

  irbs_op_decode u_decode (
    .i_opcode (i_data),
    .o_class  (dec_class)
  );

  // The opcode is on the data bus at the end of cycle one; later cycles use the stored class.
  assign cls = (state_reg == S_C1) ? dec_class : class_reg;

  assign pc_plus1  = pc_reg + `IRBS_STEP_ONE;
  assign ret_addr  = pc_reg + `IRBS_INSTR_LEN;
  assign sp_minus1 = i_stack_ptr - `IRBS_STEP_ONE;
  assign sp_minus2 = i_stack_ptr - `IRBS_STEP_TWO;

  // signed target
  // The offset is sign extended and added to the address after the two-byte instruction.
  assign rel_target = ret_addr + {{8{offset_reg[7]}}, offset_reg};

  // uncarried sum
  // The low-byte add is shown before the carry has rippled into the upper byte.
  assign idx_uncarried = {i_index[15:8], i_index[7:0] + offset_reg};

  assign idx_carried    = i_index + {`IRBS_ZERO_BYTE, offset_reg};
  assign idx_carried_p1 = idx_carried + `IRBS_STEP_ONE;

  // Last listed cycle of each class; the unrecognised class is a bare opcode fetch.
  always @* begin
    case (cls)
      `IRBS_CLS_BRANCH: last_cycle = (state_reg == S_C4);
      `IRBS_CLS_JUMP:   last_cycle = (state_reg == S_C4);
      `IRBS_CLS_RD8:    last_cycle = (state_reg == S_C5);
      `IRBS_CLS_RD16:   last_cycle = (state_reg == S_C6);
      `IRBS_CLS_STORE:  last_cycle = (state_reg == S_C6);
      `IRBS_CLS_TEST:   last_cycle = (state_reg == S_C7);
      `IRBS_CLS_BSR:    last_cycle = (state_reg == S_C8);
      default:          last_cycle = (state_reg == S_C1);
    endcase
  end

  // Address of the next opcode once the current instruction ends.
  always @* begin
    case (cls)
      `IRBS_CLS_BRANCH: pc_next = taken_reg ? rel_target : ret_addr;
      `IRBS_CLS_BSR:    pc_next = rel_target;
      `IRBS_CLS_JUMP:   pc_next = idx_carried;
      `IRBS_CLS_OTHER:  pc_next = pc_plus1;
      default:          pc_next = ret_addr;
    endcase
  end

  // Bus values for the cycle that starts at the next enabled edge.
  always @* begin
    state_next = S_C1;
    addr_next  = pc_next;
    vma_next   = 1'b1;
    rw_next    = 1'b1;
    dout_next  = `IRBS_ZERO_BYTE;
    oe_next    = 1'b0;
    if (last_cycle) begin
      state_next = S_C1;
      addr_next  = pc_next;
    end else begin
      case (state_reg)
        S_C1: begin
          state_next = S_C2;
          addr_next  = pc_plus1;
        end
        S_C2: begin
          state_next = S_C3;
          vma_next   = 1'b0;
          if (cls == `IRBS_CLS_BRANCH || cls == `IRBS_CLS_BSR) begin
            addr_next = ret_addr;
          end else begin
            addr_next = i_index;
          end
        end
        S_C3: begin
          state_next = S_C4;
          if (cls == `IRBS_CLS_BSR) begin
            addr_next = i_stack_ptr;
            rw_next   = 1'b0;
            dout_next = ret_addr[7:0];
            oe_next   = 1'b1;
          end else if (cls == `IRBS_CLS_BRANCH) begin
            addr_next = rel_target;
            vma_next  = 1'b0;
          end else begin
            addr_next = idx_uncarried;
            vma_next  = 1'b0;
          end
        end
        S_C4: begin
          state_next = S_C5;
          if (cls == `IRBS_CLS_BSR) begin
            addr_next = sp_minus1;
            rw_next   = 1'b0;
            dout_next = ret_addr[15:8];
            oe_next   = 1'b1;
          end else begin
            addr_next = idx_carried;
            vma_next  = (cls != `IRBS_CLS_STORE);
          end
        end
        S_C5: begin
          state_next = S_C6;
          if (cls == `IRBS_CLS_BSR) begin
            addr_next = sp_minus2;
            vma_next  = 1'b0;
          end else if (cls == `IRBS_CLS_RD16) begin
            addr_next = idx_carried_p1;
          end else if (cls == `IRBS_CLS_STORE) begin
            addr_next = idx_carried;
            rw_next   = 1'b0;
            dout_next = i_accum;
            oe_next   = 1'b1;
          end else begin
            addr_next = idx_carried;
            vma_next  = 1'b0;
          end
        end
        S_C6: begin
          state_next = S_C7;
          vma_next   = 1'b0;
          if (cls == `IRBS_CLS_BSR) begin
            addr_next = ret_addr;
          end else begin
            addr_next = idx_carried;
          end
        end
        S_C7: begin
          state_next = S_C8;
          addr_next  = rel_target;
          vma_next   = 1'b0;
        end
        default: begin
          state_next = S_C1;
          addr_next  = pc_reg;
        end
      endcase
    end
  end

  // Operand bytes arrive on the data bus at the end of their read cycle.
  always @* begin
    cap_high = 1'b0;
    cap_low  = 1'b0;
    if (state_reg == S_C5 && cls == `IRBS_CLS_RD16) begin
      cap_high = 1'b1;
    end
    if (state_reg == S_C5 && (cls == `IRBS_CLS_RD8 || cls == `IRBS_CLS_TEST)) begin
      cap_low = 1'b1;
    end
    if (state_reg == S_C6 && cls == `IRBS_CLS_RD16) begin
      cap_low = 1'b1;
    end
  end

  always @(posedge i_mclk) begin
    if (i_reset) begin
      state_reg       <= S_C1;
      class_reg       <= `IRBS_CLS_OTHER;
      offset_reg      <= `IRBS_ZERO_BYTE;
      taken_reg       <= 1'b0;
      pc_reg          <= `IRBS_RESET_PC;
      o_addr          <= `IRBS_RESET_PC;
      o_address_valid <= 1'b1;
      o_rw            <= 1'b1;
      o_data_out      <= `IRBS_ZERO_BYTE;
      o_data_oe       <= 1'b0;
      o_pc            <= `IRBS_RESET_PC;
      o_operand       <= `IRBS_RESET_PC;
      o_operand_valid <= 1'b0;
      o_instr_done    <= 1'b0;
    end else if (i_ce) begin
      state_reg       <= state_next;
      o_addr          <= addr_next;
      o_address_valid <= vma_next;
      o_rw            <= rw_next;
      o_data_out      <= dout_next;
      o_data_oe       <= oe_next;
      o_instr_done    <= last_cycle;
      // The test operand is captured in cycle five but its pulse follows cycle seven.
      o_operand_valid <= last_cycle && (cls == `IRBS_CLS_RD8 || cls == `IRBS_CLS_RD16 ||
                                        cls == `IRBS_CLS_TEST);
      if (state_reg == S_C1) begin
        class_reg <= dec_class;
      end
      if (state_reg == S_C2) begin
        offset_reg <= i_data;
        // The flags are settled by the time the offset arrives, so the decision is held here.
        taken_reg  <= i_cond_met;
      end
      if (cap_high) begin
        o_operand[15:8] <= i_data;
      end
      if (cap_low) begin
        o_operand[7:0] <= i_data;
      end
      if (last_cycle) begin
        pc_reg <= pc_next;
        o_pc   <= pc_next;
      end
    end else begin
      // Strobes last one enabled cycle only; while frozen they stay low.
      o_instr_done    <= 1'b0;
      o_operand_valid <= 1'b0;
    end
  end

endmodule

//--- inc/irbs_map.vh
// Constants shared by the bus sequencer and its opcode decoder.
`ifndef IRBS_MAP_VH
`define IRBS_MAP_VH

// Opcode address taken after reset.
`define IRBS_RESET_PC     16'h0000
// Address steps used when walking the instruction stream and the stack.
`define IRBS_STEP_ONE     16'h0001
`define IRBS_STEP_TWO     16'h0002
// Width of one instruction that carries an offset byte.
`define IRBS_INSTR_LEN    16'h0002
`define IRBS_ZERO_BYTE    8'h00

// Instruction classes produced by the opcode decoder.
`define IRBS_CLS_OTHER    3'h0
`define IRBS_CLS_BRANCH   3'h1
`define IRBS_CLS_BSR      3'h2
`define IRBS_CLS_JUMP     3'h3
`define IRBS_CLS_RD8      3'h4
`define IRBS_CLS_RD16     3'h5
`define IRBS_CLS_STORE    3'h6
`define IRBS_CLS_TEST     3'h7

// Opcode encoding: upper nibble selects the group, lower nibble the operation.
`define IRBS_OPG_BRANCH   4'h2
`define IRBS_OPG_INDEXED  4'hA
`define IRBS_OP_BSR       8'h8D
`define IRBS_OPL_RD8_MAX  4'h8
`define IRBS_OPL_STORE    4'h9
`define IRBS_OPL_TEST     4'hA
`define IRBS_OPL_LDSP     4'hB
`define IRBS_OPL_CMPX     4'hC
`define IRBS_OPL_LDX      4'hD
`define IRBS_OPL_JUMP     4'hE

`endif

//--- hdl/irbs_op_decode.v
// Opcode to instruction class decoder for the bus sequencer.
`include "irbs_map.vh"

module irbs_op_decode (
  input  wire [7:0] i_opcode,
  output reg  [2:0] o_class
);

  always @* begin
    o_class = `IRBS_CLS_OTHER;
    if (i_opcode[7:4] == `IRBS_OPG_BRANCH) begin
      o_class = `IRBS_CLS_BRANCH;
    end else if (i_opcode == `IRBS_OP_BSR) begin
      o_class = `IRBS_CLS_BSR;
    end else if (i_opcode[7:4] == `IRBS_OPG_INDEXED) begin
      case (i_opcode[3:0])
        `IRBS_OPL_STORE: o_class = `IRBS_CLS_STORE;
        `IRBS_OPL_TEST:  o_class = `IRBS_CLS_TEST;
        `IRBS_OPL_LDSP:  o_class = `IRBS_CLS_RD16;
        `IRBS_OPL_CMPX:  o_class = `IRBS_CLS_RD16;
        `IRBS_OPL_LDX:   o_class = `IRBS_CLS_RD16;
        `IRBS_OPL_JUMP:  o_class = `IRBS_CLS_JUMP;
        default: begin
          if (i_opcode[3:0] <= `IRBS_OPL_RD8_MAX) begin
            o_class = `IRBS_CLS_RD8;
          end else begin
            o_class = `IRBS_CLS_OTHER;
          end
        end
      endcase
    end
  end

endmodule

//--- test/irbs_mem_model.sv
// Behavioural memory standing on the system bus beside the sequencer.
module irbs_mem_model (
  input  logic        i_mclk,
  input  logic        i_ce,
  input  logic [15:0] i_addr,
  input  logic        i_address_valid,
  input  logic        i_rw,
  input  logic [7:0]  i_data_wr,
  input  logic        i_data_oe,
  output logic [7:0]  o_data
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] mem [0:65535];
  logic [7:0] last_reg = 8'h00;
  // Unwritten cells read as a one-cycle opcode, so stray fetches stay harmless.
  initial for (int k = 0; k < 65536; k++) mem[k] = 8'h01;
  // float when invalid
  // A released bus shows the inverse of the last byte, so stale data never passes as valid.
  assign o_data = (i_address_valid && i_rw) ? mem[i_addr] : ~last_reg;
  always @(posedge i_mclk) begin
    if (i_ce) begin
      last_reg <= o_data;
      if (i_address_valid && !i_rw && i_data_oe) mem[i_addr] <= i_data_wr;
    end
  end
endmodule

//--- test/irbs_seq_chk.sv
// Bus-cycle checker for the sequencer, bound to its top module.
module irbs_seq_chk (
  input logic        i_mclk,
  input logic        i_reset,
  input logic        i_ce,
  input logic [7:0]  i_data,
  input logic [15:0] i_index,
  input logic [15:0] i_stack_ptr,
  input logic [7:0]  i_accum,
  input logic        i_cond_met,
  input logic [15:0] o_addr,
  input logic        o_address_valid,
  input logic        o_rw,
  input logic [7:0]  o_data_out,
  input logic        o_data_oe,
  input logic [15:0] o_pc,
  input logic [15:0] o_operand,
  input logic        o_operand_valid,
  input logic        o_instr_done
);
  logic [15:0] p1;
  logic [15:0] p2;
  logic [7:0]  d1;
  logic [7:0]  d2;
  wire  [15:0] sx = {{8{d2[7]}}, d2};
  // A low clock enable freezes the sequencer, so only enabled edges count as cycles.
  default clocking cb @(posedge i_mclk iff i_ce); endclocking
  default disable iff (i_reset);
  always @(posedge i_mclk) begin
    if (i_ce) begin
      p1 <= o_addr;
      p2 <= p1;
      d1 <= i_data;
      d2 <= d1;
    end
  end
  property p_oe; !o_address_valid |-> o_rw && !o_data_oe; endproperty
  a_oe: assert property (p_oe) else $error("drive or write while strobe low");
  property p_done; o_instr_done |-> o_address_valid && o_rw && o_addr == o_pc; endproperty
  a_done: assert property (p_done) else $error("bad opcode fetch");
  property p_br;
    o_instr_done && i_data[7:4] == 4'h2 |=> o_addr == $past(o_addr) + 16'h0001
    ##1 !o_address_valid && o_addr == p1 + 16'h0001 ##1 !o_address_valid && o_addr == p1 + sx
    ##1 o_addr == ($past(i_cond_met, 3) ? p1 : p2);
  endproperty
  a_br: assert property (p_br) else $error("bad branch sequence");
  property p_bsr;
    o_instr_done && i_data == 8'h8D |=> ##1 !o_address_valid && o_addr == p1 + 16'h0001
    ##1 o_address_valid && !o_rw && o_addr == i_stack_ptr && o_data_out == p1[7:0]
    ##1 !o_rw && o_addr == i_stack_ptr - 16'h0001 && o_data_out == p2[15:8]
    ##1 !o_address_valid && o_addr == i_stack_ptr - 16'h0002 ##3 o_addr == p1;
  endproperty
  a_bsr: assert property (p_bsr) else $error("bad subroutine call");
  property p_jmp;
    o_instr_done && i_data == 8'hAE |=> ##1 !o_address_valid && o_addr == i_index
    ##1 !o_address_valid && o_addr == {i_index[15:8], i_index[7:0] + d2}
    ##1 o_addr == i_index + $past(d2);
  endproperty
  a_jmp: assert property (p_jmp) else $error("bad indexed jump");
  property p_rd8;
    o_instr_done && i_data[7:4] == 4'hA && i_data[3:0] <= 4'h8 |=> ##3 o_address_valid
    && o_rw && o_addr == i_index + $past(d2) ##1 o_operand_valid && o_instr_done;
  endproperty
  a_rd8: assert property (p_rd8) else $error("bad indexed read");
  property p_rd16;
    o_instr_done && i_data inside {8'hAB, 8'hAC, 8'hAD} |=> ##3 o_address_valid
    && o_addr == i_index + $past(d2) ##1 o_address_valid && o_rw
    && o_addr == $past(o_addr) + 16'h0001 ##1 o_operand_valid;
  endproperty
  a_rd16: assert property (p_rd16) else $error("bad double read");
  property p_sta;
    o_instr_done && i_data == 8'hA9 |=> ##3 !o_address_valid && o_addr == i_index + $past(d2)
    ##1 o_address_valid && !o_rw && o_data_oe && o_addr == $past(o_addr)
    && o_data_out == $past(i_accum);
  endproperty
  a_sta: assert property (p_sta) else $error("bad indexed store");
  property p_tst;
    o_instr_done && i_data == 8'hAA |=> ##3 o_address_valid && o_rw ##1 !o_address_valid
    ##1 !o_address_valid && o_rw && o_addr == $past(o_addr) ##1 o_instr_done;
  endproperty
  a_tst: assert property (p_tst) else $error("bad operand test");
  c_br: cover property (o_instr_done && i_data[7:4] == 4'h2);
  c_bsr: cover property (o_address_valid && !o_rw && o_addr == i_stack_ptr);
  c_tst: cover property (o_instr_done && i_data == 8'hAA);
endmodule
bind irbs_sequencer irbs_seq_chk chk_i (.*);

//--- test/tb_indexed_relative_bus_sequencer.sv
// Self-checking bench for the indexed and relative bus sequencer.
module tb_indexed_relative_bus_sequencer;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [15:0] X = 16'h1234;
  localparam logic [15:0] SP = 16'h01FF;
  localparam logic [7:0] ACC = 8'h7E;
  logic i_mclk = 1'b0;
  logic i_reset = 1'b1;
  logic i_cond_met = 1'b0;
  logic i_ce = 1'b1;
  logic [7:0] i_data;
  logic [7:0] o_data_out;
  logic [15:0] o_addr, o_pc, o_operand, p;
  logic o_address_valid, o_rw, o_data_oe, o_operand_valid, o_instr_done;
  int err_count = 0;
  int n_compared = 0;
  always #12.5 i_mclk = ~i_mclk;
  irbs_sequencer DUT (.i_mclk(i_mclk), .i_reset(i_reset), .i_ce(i_ce), .i_data(i_data),
    .i_index(X), .i_stack_ptr(SP), .i_accum(ACC), .i_cond_met(i_cond_met),
    .o_addr(o_addr), .o_address_valid(o_address_valid), .o_rw(o_rw),
    .o_data_out(o_data_out), .o_data_oe(o_data_oe), .o_pc(o_pc), .o_operand(o_operand),
    .o_operand_valid(o_operand_valid), .o_instr_done(o_instr_done));
  irbs_mem_model mem_i (.i_mclk(i_mclk), .i_ce(i_ce), .i_addr(o_addr),
    .i_address_valid(o_address_valid), .i_rw(o_rw), .i_data_wr(o_data_out),
    .i_data_oe(o_data_oe), .o_data(i_data));
  task automatic print_verdict();
    $display("compared %0d, wrong %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic cyc(input logic [15:0] a, input logic v, input logic w);
    chk({o_data_oe, o_address_valid, o_rw, o_addr}, {~w, v, w, a});
    @(negedge i_mclk);
  endtask
  // A low enable must freeze the bus mid-instruction and suppress the instruction-done pulse.
  task automatic hold(input logic [15:0] a);
    i_ce = 1'b0;
    repeat (3) begin
      @(negedge i_mclk);
      chk({o_instr_done, o_rw, o_addr}, {1'b0, 1'b0, a});
    end
    i_ce = 1'b1;
  endtask
  task automatic fetch(input logic [15:0] a);
    chk(o_instr_done, 1'b1);
    cyc(a, 1'b1, 1'b1);
  endtask
  task automatic put(input logic [15:0] a, input logic [7:0] op, input logic [7:0] off);
    mem_i.mem[a] = op;
    mem_i.mem[a + 16'h0001] = off;
  endtask
  task automatic t_br(input logic [15:0] pc, input logic [7:0] op, input logic [7:0] off,
                      input logic c);
    logic [15:0] r;
    r = pc + 16'h0002;
    put(pc, op, off);
    i_cond_met = c;
    fetch(pc);
    cyc(pc + 16'h0001, 1'b1, 1'b1);
    cyc(r, 1'b0, 1'b1);
    cyc(r + {{8{off[7]}}, off}, 1'b0, 1'b1);
    p = c ? r + {{8{off[7]}}, off} : r;
    $display("branch test done");
  endtask
  task automatic t_bsr(input logic [15:0] pc, input logic [7:0] off);
    logic [15:0] r;
    r = pc + 16'h0002;
    put(pc, 8'h8D, off);
    fetch(pc);
    cyc(pc + 16'h0001, 1'b1, 1'b1);
    cyc(r, 1'b0, 1'b1);
    cyc(SP, 1'b1, 1'b0);
    hold(SP - 16'h0001);
    cyc(SP - 16'h0001, 1'b1, 1'b0);
    cyc(SP - 16'h0002, 1'b0, 1'b1);
    cyc(r, 1'b0, 1'b1);
    p = r + {{8{off[7]}}, off};
    cyc(p, 1'b0, 1'b1);
    chk({mem_i.mem[SP - 16'h0001], mem_i.mem[SP]}, r);
    $display("subroutine test done");
  endtask
  task automatic idx_head(input logic [15:0] pc, input logic [7:0] op, input logic [7:0] off);
    put(pc, op, off);
    fetch(pc);
    cyc(pc + 16'h0001, 1'b1, 1'b1);
    cyc(X, 1'b0, 1'b1);
    cyc({X[15:8], X[7:0] + off}, 1'b0, 1'b1);
    p = pc + 16'h0002;
  endtask
  task automatic t_jmp(input logic [15:0] pc, input logic [7:0] off);
    idx_head(pc, 8'hAE, off);
    p = X + {8'h00, off};
    chk(o_addr, p);
    $display("jump test done");
  endtask
  task automatic t_rd(input logic [15:0] pc, input logic [7:0] op, input logic [7:0] off,
                      input logic w);
    logic [15:0] s;
    s = X + {8'h00, off};
    mem_i.mem[s] = 8'hA5;
    mem_i.mem[s + 16'h0001] = 8'h3C;
    idx_head(pc, op, off);
    cyc(s, 1'b1, 1'b1);
    if (w) cyc(s + 16'h0001, 1'b1, 1'b1);
    chk({o_operand_valid, w ? o_operand : {8'h00, o_operand[7:0]}},
        {1'b1, w ? 16'hA53C : 16'h00A5});
    $display("indexed read test done");
  endtask
  task automatic t_sta(input logic [15:0] pc, input logic [7:0] off);
    logic [15:0] s;
    s = X + {8'h00, off};
    mem_i.mem[s] = 8'h00;
    idx_head(pc, 8'hA9, off);
    cyc(s, 1'b0, 1'b1);
    chk(o_data_out, ACC);
    cyc(s, 1'b1, 1'b0);
    chk(mem_i.mem[s], ACC);
    $display("store test done");
  endtask
  task automatic t_tst(input logic [15:0] pc, input logic [7:0] off);
    logic [15:0] s;
    s = X + {8'h00, off};
    mem_i.mem[s] = 8'h5A;
    idx_head(pc, 8'hAA, off);
    cyc(s, 1'b1, 1'b1);
    cyc(s, 1'b0, 1'b1);
    cyc(s, 1'b0, 1'b1);
    chk({o_operand_valid, mem_i.mem[s], o_operand[7:0]}, {1'b1, 8'h5A, 8'h5A});
    $display("operand test done");
  endtask
  initial begin
    repeat (5) @(negedge i_mclk);
    i_reset = 1'b0;
    cyc(16'h0000, 1'b1, 1'b1);
    t_br(16'h0001, 8'h20, 8'h10, 1'b1);
    t_br(p, 8'h27, 8'h80, 1'b0);
    t_br(p, 8'h20, 8'h80, 1'b1);
    t_bsr(p, 8'h7F);
    t_jmp(p, 8'hFF);
    t_rd(p, 8'hAD, 8'hCC, 1'b1);
    for (int k = 0; k < 2; k++) t_rd(p, 8'hAB + k[7:0], k[7:0], 1'b1);
    for (int k = 0; k < 9; k++) t_rd(p, 8'hA0 + k[7:0], k[7:0], 1'b0);
    t_sta(p, 8'h00);
    t_tst(p, 8'h02);
    fetch(p);
    print_verdict();
  end
  // The whole run needs about 110 cycles; this bound only catches a hang.
  initial begin
    repeat (3000) @(posedge i_mclk);
    err_count++;
    print_verdict();
  end
endmodule
